// [design/wk_counter.sv]
// Wake-up event counter with AHB-Lite register slave
`timescale 1ns/1ns
`default_nettype none
`include "wk_regs.svh"

// Contract
// - Software picks per pin which inputs may raise wake events.
// - Each pin has a polarity bit choosing its active edge.
// - With polarity 0 a rising edge on a selected pin sets the hit flag.
// - An active edge loads the debounce timer, which drops once per ms.
// - The debounce value is six bits, zero to sixty-three ms.
// - At timer zero with the hit flag still set the count goes up by one.
// - After a count the sequencer waits for the reverse edge, then idles.
// - Count equal to target clears the count and raises the enabled irq.
// - Any write to the irq clear location drops the pending match status; the event status stays set.
// - Any write to the counter clear location zeroes the count.
// - The count can be read at any time without disturbing counting.
// - With every pin selected, an active edge on any one pin wakes the system.
module wk_counter #(
	parameter int TICK_CYCLES = `WK_TICK_CYCLES
) (
	input  wire logic                  i_clk,
	input  wire logic                  i_reset_n,
	input  wire logic                  i_hsel,
	input  wire logic [31:0]           i_haddr,
	input  wire logic [1:0]            i_htrans,
	input  wire logic                  i_hwrite,
	input  wire logic [2:0]            i_hsize,
	input  wire logic [31:0]           i_hwdata,
	input  wire logic                  i_hready,
	output logic      [31:0]           o_hrdata,
	output logic                       o_hreadyout,
	output logic                       o_hresp,
	input  wire logic [`WK_NPINS-1:0]  i_pins,
	output logic                       o_irq
);
	import wk_pkg::*;

	localparam int NP = `WK_NPINS;
	localparam int CW = `WK_CNT_W;

	logic                rs1_r, rst_n;
	logic [NP-1:0]       ps1_r, ps2_r, pprev_r;
	logic [NP-1:0]       sel_r, pol_r, act_e, rev_e;
	logic [5:0]          deb_val_r, deb_r;
	logic [CW-1:0]       tgt_r, cnt_r, cnt_inc;
	logic [17:0]         tick_r;
	logic                tick, key_hit_r, ev_fire, ev_match;
	logic                wr_irqclr, wr_cntclr;
	logic [`WK_STS_W-1:0] sts_r, ien_r, sts_set, sts_clr;
	wk_state_t           st_r;
	wk_aphase_t          ap_r;
	//----------------------------------------------------------------
	// Reset release and pin synchronisers
	//----------------------------------------------------------------
	// Two-stage reset release
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rs1_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rs1_r <= 1'b1;
			rst_n <= rs1_r;
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			ps1_r   <= '0;
			ps2_r   <= '0;
			pprev_r <= '0;
		end else begin
			ps1_r   <= i_pins;
			ps2_r   <= ps1_r;
			pprev_r <= ps2_r;
		end
	end

	// Per-pin edge qualification
	genvar g;
	generate
		for (g = 0; g < NP; g++) begin : g_pin
			assign act_e[g] = sel_r[g] & (pol_r[g] ?
				(pprev_r[g] & ~ps2_r[g]) : (~pprev_r[g] & ps2_r[g]));
			assign rev_e[g] = sel_r[g] & (pol_r[g] ?
				(~pprev_r[g] & ps2_r[g]) : (pprev_r[g] & ~ps2_r[g]));
		end
	endgenerate
	//----------------------------------------------------------------
	// Millisecond tick and event sequencer
	//----------------------------------------------------------------
	assign tick = (tick_r == 18'(TICK_CYCLES - 1));

	// Tick prescaler, restarted on each load
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n)
			tick_r <= '0;
		else if ((st_r == WK_ST_IDLE) || tick)
			tick_r <= '0;
		else
			tick_r <= tick_r + 18'h00001;
	end

	assign ev_fire  = (st_r == WK_ST_DEB) && (deb_r == 6'h00) && key_hit_r;
	assign cnt_inc  = cnt_r + 8'h01;
	assign ev_match = ev_fire && (cnt_inc == tgt_r);

	// Sequencer, debounce timer and hit flag
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r      <= WK_ST_IDLE;
			deb_r     <= '0;
			key_hit_r <= 1'b0;
		end else begin
			case (st_r)
				WK_ST_IDLE: begin
					if (|act_e) begin
						st_r      <= WK_ST_DEB;
						deb_r     <= deb_val_r;
						key_hit_r <= 1'b1;
					end
				end
				WK_ST_DEB: begin
					if (|rev_e)
						key_hit_r <= 1'b0;
					if (deb_r == 6'h00) begin
						st_r <= key_hit_r ? WK_ST_WAIT : WK_ST_IDLE;
					end else if (tick) begin
						deb_r <= deb_r - 6'h01;
					end
				end
				WK_ST_WAIT: begin
					if (|rev_e) begin
						st_r      <= WK_ST_IDLE;
						key_hit_r <= 1'b0;
					end
				end
				default: st_r <= WK_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n)
			cnt_r <= '0;
		else if (wr_cntclr || ev_match)
			cnt_r <= '0;
		else if (ev_fire)
			cnt_r <= cnt_inc;
	end
	//----------------------------------------------------------------
	// Interrupt status
	//----------------------------------------------------------------
	assign sts_set = {ev_fire, ev_match};
	assign sts_clr = (ap_r.valid && ap_r.write && ap_r.addr == `WK_OFS_STSCLR)
		? i_hwdata[`WK_STS_W-1:0] : '0;

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n)
			sts_r <= '0;
		else
			sts_r <= sts_set | (sts_r & ~sts_clr &
				~{1'b0, wr_irqclr});
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n)
			o_irq <= 1'b0;
		else
			o_irq <= |(sts_r & ien_r);
	end
	//----------------------------------------------------------------
	// AHB-Lite slave
	//----------------------------------------------------------------
	// Address phase capture
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n)
			ap_r <= '0;
		else begin
			ap_r.valid <= i_hsel && i_htrans[1] && i_hready;
			ap_r.write <= i_hwrite;
			ap_r.addr  <= {i_haddr[7:2], 2'b00};
		end
	end

	assign wr_irqclr = ap_r.valid && ap_r.write
		&& (ap_r.addr == `WK_OFS_IRQCLR);
	assign wr_cntclr = ap_r.valid && ap_r.write
		&& (ap_r.addr == `WK_OFS_CNTCLR);

	// Writable configuration
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_r     <= `WK_RST_SEL;
			pol_r     <= `WK_RST_POL;
			deb_val_r <= `WK_RST_DEB;
			tgt_r     <= `WK_RST_TARGET;
			ien_r     <= `WK_RST_IEN;
		end else if (ap_r.valid && ap_r.write) begin
			if (ap_r.addr == `WK_OFS_SEL)
				sel_r <= i_hwdata[NP-1:0];
			else if (ap_r.addr == `WK_OFS_POL)
				pol_r <= i_hwdata[NP-1:0];
			else if (ap_r.addr == `WK_OFS_CTRL)
				deb_val_r <= i_hwdata[`WK_DEB_MSB:`WK_DEB_LSB];
			else if (ap_r.addr == `WK_OFS_TARGET)
				tgt_r <= i_hwdata[CW-1:0];
			else if (ap_r.addr == `WK_OFS_IEN)
				ien_r <= i_hwdata[`WK_STS_W-1:0];
		end
	end

	// read data registered in address phase
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n)
			o_hrdata <= '0;
		else if (i_hsel && i_htrans[1] && i_hready && !i_hwrite) begin
			if (i_haddr[7:0] == `WK_OFS_SEL)
				o_hrdata <= {8'h00, sel_r};
			else if (i_haddr[7:0] == `WK_OFS_POL)
				o_hrdata <= {8'h00, pol_r};
			else if (i_haddr[7:0] == `WK_OFS_CTRL)
				o_hrdata <= {26'h0000000, deb_val_r};
			else if (i_haddr[7:0] == `WK_OFS_TARGET)
				o_hrdata <= {24'h000000, tgt_r};
			else if (i_haddr[7:0] == `WK_OFS_COUNT)
				o_hrdata <= {24'h000000, cnt_r};
			else if (i_haddr[7:0] == `WK_OFS_STS)
				o_hrdata <= {30'h00000000, sts_r};
			else if (i_haddr[7:0] == `WK_OFS_IEN)
				o_hrdata <= {30'h00000000, ien_r};
			else
				o_hrdata <= '0;
		end
	end

	// Zero-wait, always OKAY
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_hreadyout <= 1'b0;
			o_hresp     <= 1'b0;
		end else begin
			o_hreadyout <= 1'b1;
			o_hresp     <= 1'b0;
		end
	end
	//----------------------------------------------------------------
	// Assertions
	//----------------------------------------------------------------
	property p_idle_hold;
		@(posedge i_clk) disable iff (!rst_n)
		(st_r == WK_ST_IDLE) && (act_e == '0) |=> st_r == WK_ST_IDLE;
	endproperty
	a_idle_hold: assert property (p_idle_hold)
		else $error("Idle left without an active edge");
	property p_start;
		@(posedge i_clk) disable iff (!rst_n)
		(st_r == WK_ST_IDLE) && (|act_e) |=> (st_r == WK_ST_DEB)
			&& key_hit_r && (deb_r == $past(deb_val_r));
	endproperty
	a_start: assert property (p_start)
		else $error("Active edge did not load debounce");
	property p_rise;
		@(posedge i_clk) disable iff (!rst_n)
		(st_r == WK_ST_IDLE) && sel_r[0] && !pol_r[0]
			&& $rose(ps2_r[0]) |=> st_r == WK_ST_DEB;
	endproperty
	a_rise: assert property (p_rise)
		else $error("Rising edge on pin 0 missed");
	property p_fall;
		@(posedge i_clk) disable iff (!rst_n)
		(st_r == WK_ST_IDLE) && |(sel_r & pol_r & $past(ps2_r)
			& ~ps2_r) |=> st_r == WK_ST_DEB;
	endproperty
	a_fall: assert property (p_fall)
		else $error("Falling edge on a pin missed");
	property p_count;
		@(posedge i_clk) disable iff (!rst_n)
		ev_fire && !ev_match && !wr_cntclr |=> cnt_r == $past(cnt_inc);
	endproperty
	a_count: assert property (p_count)
		else $error("Event not counted");
	property p_wait;
		@(posedge i_clk) disable iff (!rst_n)
		(st_r == WK_ST_WAIT) && (rev_e == '0) |=> st_r == WK_ST_WAIT;
	endproperty
	a_wait: assert property (p_wait)
		else $error("Left wait without reverse edge");
	property p_match;
		@(posedge i_clk) disable iff (!rst_n)
		ev_match |=> (cnt_r == '0) && sts_r[`WK_STS_MATCH]
			##1 (o_irq == (ien_r[`WK_STS_MATCH] | o_irq));
	endproperty
	a_match: assert property (p_match)
		else $error("Target match not handled");
	property p_irqclr;
		@(posedge i_clk) disable iff (!rst_n)
		wr_irqclr && !ev_match |=> !sts_r[`WK_STS_MATCH];
	endproperty
	a_irqclr: assert property (p_irqclr)
		else $error("Irq clear ignored");
	property p_cntclr;
		@(posedge i_clk) disable iff (!rst_n)
		wr_cntclr |=> cnt_r == '0;
	endproperty
	a_cntclr: assert property (p_cntclr)
		else $error("Counter clear ignored");
	property p_rdcnt;
		@(posedge i_clk) disable iff (!rst_n)
		i_hsel && i_htrans[1] && i_hready && !i_hwrite
			&& (i_haddr[7:0] == `WK_OFS_COUNT)
			|=> o_hrdata == {24'h000000, $past(cnt_r)};
	endproperty
	a_rdcnt: assert property (p_rdcnt)
		else $error("Count readback wrong");
	c_count: cover property (@(posedge i_clk) disable iff (!rst_n)
		ev_fire && !ev_match);
	c_match: cover property (@(posedge i_clk) disable iff (!rst_n)
		ev_match);
	c_bounce: cover property (@(posedge i_clk) disable iff (!rst_n)
		(st_r == WK_ST_DEB) && (deb_r == 6'h00) && !key_hit_r);
	c_irq: cover property (@(posedge i_clk) disable iff (!rst_n)
		$rose(o_irq));
endmodule
`default_nettype wire

// [design/wk_pkg.sv]
// Types shared by the wake event counter
package wk_pkg;
	// Event sequencer states, one-hot
	typedef enum logic [2:0] {
		WK_ST_IDLE = 3'b001,
		WK_ST_DEB  = 3'b010,
		WK_ST_WAIT = 3'b100
	} wk_state_t;
	// Latched bus address phase
	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] addr;
	} wk_aphase_t;
endpackage

// [design/wk_regs.svh]
// Register map, field layout, reset values and timing of the wake counter
`ifndef WK_REGS_SVH
`define WK_REGS_SVH
`define WK_NPINS        24
`define WK_CNT_W        8
`define WK_OFS_SEL      8'h00
`define WK_OFS_POL      8'h04
`define WK_OFS_CTRL     8'h08
`define WK_OFS_TARGET   8'h0c
`define WK_OFS_IRQCLR   8'h10
`define WK_OFS_CNTCLR   8'h14
`define WK_OFS_COUNT    8'h18
`define WK_OFS_STS      8'h1c
`define WK_OFS_STSCLR   8'h20
`define WK_OFS_IEN      8'h24
`define WK_DEB_LSB      0
`define WK_DEB_MSB      5
`define WK_STS_MATCH    0
`define WK_STS_EVENT    1
`define WK_STS_W        2
`define WK_RST_SEL      24'h000000
`define WK_RST_POL      24'h000000
`define WK_RST_DEB      6'h00
`define WK_RST_TARGET   8'h00
`define WK_RST_IEN      2'h0
`define WK_TICK_NS      1000000
`define WK_CLK_NS       4
`define WK_TICK_CYCLES  (`WK_TICK_NS / `WK_CLK_NS)
`endif

// [tb/testbench.sv]
// Self-checking bench for the wake event counter
`timescale 1ns/1ns
`default_nettype none
`include "wk_regs.svh"
module testbench;
	logic                 i_clk, i_reset_n, i_hsel, i_hwrite;
	logic [31:0]          i_haddr, i_hwdata, o_hrdata, q;
	logic [1:0]           i_htrans;
	logic [2:0]           i_hsize;
	logic                 o_hreadyout, o_hresp, o_irq;
	logic [`WK_NPINS-1:0] pins;
	int                   n_mismatch, compares;

	wk_counter #(.TICK_CYCLES(8)) dut (
		.i_clk(i_clk), .i_reset_n(i_reset_n), .i_hsel(i_hsel),
		.i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
		.i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
		.o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
		.i_pins(pins), .o_irq(o_irq));
	wk_pin_model sw (.i_clk(i_clk), .o_pins(pins));

	// 250 MHz clock
	initial i_clk = 1'b0;
	always #2 i_clk = ~i_clk;

	// ------------------------------
	// Bus and compare helpers
	// ------------------------------
	task automatic chk(input logic [31:0] got, exp, input string m);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t %s", $time, m);
		end
	endtask
	// Wait for hready high at a rising edge, bounded
	task automatic wait_rdy();
		int n;
		n = 0;
		@(posedge i_clk);
		while (o_hreadyout !== 1'b1 && n < 50) begin
			@(posedge i_clk);
			n++;
		end
		if (n >= 50)
			chk(32'h0, 32'h1, "bus hang");
	endtask
	// One single word transfer; read data lands in q
	task automatic xfer(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		i_hsel <= 1'b1;
		i_haddr <= {24'h0, a};
		i_htrans <= 2'b10;
		i_hwrite <= w;
		wait_rdy();
		i_hsel <= 1'b0;
		i_htrans <= 2'b00;
		i_hwdata <= d;
		wait_rdy();
		q = o_hrdata;
		chk({31'h0, o_hresp}, 32'h0, "response not okay");
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, string m);
		xfer(1'b0, a, 32'h0);
		chk(q, e, m);
	endtask
	task automatic irq_is(input logic e, input string m);
		chk({31'h0, o_irq}, {31'h0, e}, m);
	endtask
	task automatic give_verdict();
		$display("n_mismatch %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge i_clk);
		n_mismatch++;
		give_verdict();
	end

	// Main sequence
	initial begin
		logic [7:0] ofs [7];
		ofs = '{`WK_OFS_SEL, `WK_OFS_POL, `WK_OFS_CTRL, `WK_OFS_TARGET,
			`WK_OFS_COUNT, `WK_OFS_STS, `WK_OFS_IEN};
		i_reset_n = 1'b0;
		i_hsel = 1'b0;
		i_haddr = 32'h0;
		i_htrans = 2'b00;
		i_hwrite = 1'b0;
		i_hsize = 3'h2;
		i_hwdata = 32'h0;
		n_mismatch = 0;
		compares = 0;
		repeat (16) @(posedge i_clk);
		i_reset_n <= 1'b1;
		wait_rdy();
		for (int i = 0; i < 7; i++)
			rdc(ofs[i], 32'h0, "reset value");
		wr(8'h28, 32'hffffffff);
		rdc(8'h28, 32'h0, "unmapped read");
		wr(`WK_OFS_CTRL, 32'hff);
		rdc(`WK_OFS_CTRL, 32'h3f, "debounce width");
		wr(`WK_OFS_CTRL, 32'h2);
		wr(`WK_OFS_TARGET, 32'h3);
		wr(`WK_OFS_IEN, 32'h1);
		wr(`WK_OFS_SEL, 32'h18);
		sw.pulse(5, 40);
		rdc(`WK_OFS_COUNT, 32'h0, "unselected pin");
		sw.pulse(3, 40);
		rdc(`WK_OFS_COUNT, 32'h1, "rising edge");
		rdc(`WK_OFS_STS, 32'h2, "event status");
		sw.pulse(3, 3);
		rdc(`WK_OFS_COUNT, 32'h1, "bounce ignored");
		wr(`WK_OFS_CNTCLR, 32'h5a);
		rdc(`WK_OFS_COUNT, 32'h0, "counter clear");
		// Second active edge while waiting for the reverse one
		sw.flip(3);
		repeat (40) @(posedge i_clk);
		sw.pulse(4, 40);
		// Pin 3 falls while idle, nothing counted
		sw.flip(3);
		repeat (20) @(posedge i_clk);
		rdc(`WK_OFS_COUNT, 32'h1, "edge outside idle");
		sw.pulse(3, 40);
		sw.pulse(3, 40);
		rdc(`WK_OFS_COUNT, 32'h0, "target match");
		irq_is(1'b1, "irq raised");
		wr(`WK_OFS_IRQCLR, 32'h0);
		repeat (2) @(posedge i_clk);
		irq_is(1'b0, "irq cleared");
		// Falling edge pin with the interrupt masked
		wr(`WK_OFS_SEL, 32'h0);
		sw.flip(7);
		wr(`WK_OFS_POL, 32'h80);
		wr(`WK_OFS_SEL, 32'h80);
		wr(`WK_OFS_TARGET, 32'h2);
		wr(`WK_OFS_IEN, 32'h0);
		sw.pulse(7, 40);
		rdc(`WK_OFS_COUNT, 32'h1, "falling edge");
		sw.pulse(7, 40);
		rdc(`WK_OFS_STS, 32'h3, "masked match");
		irq_is(1'b0, "irq masked");
		wr(`WK_OFS_IEN, 32'h1);
		repeat (2) @(posedge i_clk);
		irq_is(1'b1, "irq on enable");
		wr(`WK_OFS_STSCLR, 32'h3);
		rdc(`WK_OFS_STS, 32'h0, "status clear");
		irq_is(1'b0, "irq after clear");
		// Every pin selected, longest debounce
		wr(`WK_OFS_TARGET, 32'h10);
		wr(`WK_OFS_SEL, 32'hffffff);
		sw.pulse(23, 40);
		rdc(`WK_OFS_COUNT, 32'h1, "any pin wakes");
		wr(`WK_OFS_CTRL, 32'h3f);
		sw.flip(0);
		repeat (440) @(posedge i_clk);
		rdc(`WK_OFS_COUNT, 32'h1, "still debouncing");
		repeat (100) @(posedge i_clk);
		rdc(`WK_OFS_COUNT, 32'h2, "after full debounce");
		sw.flip(0);
		give_verdict();
	end
endmodule
`default_nettype wire

// [tb/wk_pin_model.sv]
// Switch bank model driving the wake input pins
`timescale 1ns/1ns
`default_nettype none
`include "wk_regs.svh"
module wk_pin_model (
	input  wire logic                 i_clk,
	output logic      [`WK_NPINS-1:0] o_pins
);
	// Pins idle low from time zero
	initial o_pins = '0;
	// Flip one pin just after a clock edge
	task automatic flip(input int pin);
		@(posedge i_clk);
		o_pins[pin] <= ~o_pins[pin];
	endtask
	task automatic pulse(input int pin, input int hold);
		flip(pin);
		repeat ((hold < 2) ? 2 : hold) @(posedge i_clk);
		flip(pin);
		repeat (12) @(posedge i_clk);
	endtask
endmodule
`default_nettype wire
